// ### shared/strap_cfg_defines.svh
// timing counts, pin indices and reset values for the strap configuration loader
// assumes one clock at 125 MHz; included by the package and the bench
//
// Operation
// - reset sequence loads configuration, powers regulators, starts clocks, calibrates and locks PLL
// - initial configuration merges straps, OTP configuration, external EEPROM and register defaults
// - strap pin levels are captured at the master reset rising edge; here taken on the third clock edge after release
// - pin 9 low selects SPI, high selects I2C; pin pulled up
// - strap-derived settings stay writable through the serial port afterwards; here only port select and address bit two are writable
// - no address strap pin assigned gives address bit two equal zero
// - address strap affects only address bit two, and nothing under SPI
// - several address strap pins: the highest-index pin wins
// - stored configuration or serial writes may replace address and port setup
// - a captured high on an EEPROM-disable pin skips external EEPROM reads
// - with no EEPROM-disable pin the EEPROM search is attempted
// - several EEPROM-disable pins are combined by logical OR
// - with no select pins assigned, pins 3 to 0 form the select
// - undriven default select pins read all ones, choosing configuration 15
// - assigned select pins form the value in index order, lowest is LSB
// - fewer than four select pins fill low bits, upper bits zero
// - more than four select pins form a wider select word
// - strap assignments come from the OTP info block; blank parts keep defaults
// - select straps choose stored configurations; no effect on blank parts
// - defaults: clocks off, pins inputs; serial programming accepted after reset; here writes are taken only once loading is done
// - registers first return to defaults, then OTP contents are applied
// - a selected configuration with bad checksum is skipped, defaults remain
`ifndef STRAP_CFG_DEFINES_SVH
`define STRAP_CFG_DEFINES_SVH

`define GPIO_COUNT 10
`define GPIO_IDX_W 4
`define SEL_W 10
`define PORT_SEL_PIN 9
`define DEF_SEL_MASK 10'h00F
`define SEL_NARROW_W 4
`define CLK_PERIOD_PS 8000
`define PLL_CAL_TIME_NS 1000
`define PLL_CAL_CYCLES ((`PLL_CAL_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define OUT_COUNT 12
`define RST_OUT_EN 12'h000
`define RST_GPIO_DIR 10'h000

`endif

// ### shared/strap_cfg_pkg.sv
// types shared by the strap configuration loader
// assumes strap_cfg_defines.svh is on the include path
`include "strap_cfg_defines.svh"
package strap_cfg_pkg;

  typedef struct packed {
    logic [`GPIO_COUNT-1:0] sel_mask;
    logic [`GPIO_COUNT-1:0] addr_mask;
    logic [`GPIO_COUNT-1:0] eedis_mask;
    logic programmed;
  } strap_assign_type;

  typedef struct packed {
    logic port_i2c;
    logic slave_address_bit_two;
    logic eeprom_skip;
    logic [`SEL_W-1:0] cfg_sel;
  } strap_result_type;

  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_defaults = 3'b001,
    st_otp = 3'b011,
    st_eeprom = 3'b010,
    st_pll = 3'b110,
    st_done = 3'b111
  } seq_state_type;

endpackage

// ### src/strap_cfg_loader.sv
// reset strap capture and initial configuration sequence
// assumes rst_b is the synchronised master_reset_low; straps are async pins
module strap_cfg_loader
  import strap_cfg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [`GPIO_COUNT-1:0] gpio_in,
  input wire strap_assign_type assign_in,
  input wire logic otp_done,
  input wire logic otp_crc_ok,
  input wire logic eeprom_done,
  input wire logic pll_locked,
  input wire logic reg_wr,
  input wire logic reg_wr_i2c,
  input wire logic reg_wr_a2,
  output strap_result_type result_r,
  output logic otp_load_r,
  output logic otp_apply_r,
  output logic eeprom_start_r,
  output logic pll_cal_r,
  output logic regs_default_r,
  output logic [`OUT_COUNT-1:0] out_en_r,
  output logic [`GPIO_COUNT-1:0] gpio_dir_r,
  output logic serial_ready_r
);

  logic [`GPIO_COUNT-1:0] sync1_r;
  logic [`GPIO_COUNT-1:0] sync2_r;
  logic [`GPIO_COUNT-1:0] cap_r;
  logic [1:0] warm_r;
  logic cap_now;
  logic held_r;
  strap_assign_type asg_r;
  logic [`SEL_W-1:0] sel_packed;
  seq_state_type state_r;
  seq_state_type state_nxt;
  logic [15:0] cal_cnt_r;
  logic addr_bit;
  logic [`GPIO_COUNT-1:0] addr_hits;

  // two-stage synchroniser on the strap pins
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_r <= '1;
      sync2_r <= '1;
    end else begin
      sync1_r <= gpio_in;
      sync2_r <= sync1_r;
    end
  end

  // capture on the third edge after release, once the synchroniser holds pin values
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      warm_r <= 2'h0;
    end else if (warm_r != 2'h3) begin
      warm_r <= warm_r + 2'h1;
    end
  end
  assign cap_now = (warm_r == 2'h2);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cap_r <= '1;
      asg_r <= '0;
      held_r <= 1'b0;
    end else if (cap_now) begin
      cap_r <= sync2_r;
      asg_r <= assign_in.programmed ? assign_in : '0;
      held_r <= 1'b1;
    end
  end

  strap_pack u_pack (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .load(warm_r == 2'h3 && state_r == st_idle),
    .mask((asg_r.sel_mask == '0) ? `DEF_SEL_MASK : asg_r.sel_mask),
    .bits(cap_r),
    .packed_r(sel_packed)
  );

  // highest-index assigned address pin wins
  always_comb begin
    addr_bit = 1'b0;
    for (int i = 0; i < `GPIO_COUNT; i++) begin
      if (asg_r.addr_mask[i]) begin
        addr_bit = cap_r[i];
      end
    end
  end
  assign addr_hits = asg_r.eedis_mask & cap_r;

  // sequence of the initial configuration
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      st_idle: begin
        if (warm_r == 2'h3) state_nxt = st_defaults;
      end
      st_defaults: begin
        state_nxt = st_otp;
      end
      st_otp: begin
        // a blank part has no stored configuration to wait for
        if (otp_done || !asg_r.programmed) state_nxt = st_eeprom;
      end
      st_eeprom: begin
        if (result_r.eeprom_skip || eeprom_done) state_nxt = st_pll;
      end
      st_pll: begin
        if (cal_cnt_r == 16'h0000 && pll_locked) state_nxt = st_done;
      end
      st_done: begin
        state_nxt = st_done;
      end
      default: state_nxt = st_idle;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= st_idle;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cal_cnt_r <= 16'(`PLL_CAL_CYCLES);
    end else if (state_r == st_pll && cal_cnt_r != 16'h0000) begin
      cal_cnt_r <= cal_cnt_r - 16'h0001;
    end
  end

  // strap results; serial writes may override once loading is done
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      result_r <= '0;
    end else if (state_r == st_defaults) begin
      result_r.port_i2c <= cap_r[`PORT_SEL_PIN];
      result_r.slave_address_bit_two <= cap_r[`PORT_SEL_PIN] & addr_bit;
      result_r.eeprom_skip <= |addr_hits;
      result_r.cfg_sel <= sel_packed;
    end else if (reg_wr && state_r == st_done) begin
      result_r.port_i2c <= reg_wr_i2c;
      result_r.slave_address_bit_two <= reg_wr_i2c & reg_wr_a2;
    end
  end

  // loading strobes
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      regs_default_r <= 1'b1;
      otp_load_r <= 1'b0;
      otp_apply_r <= 1'b0;
      eeprom_start_r <= 1'b0;
      pll_cal_r <= 1'b0;
      serial_ready_r <= 1'b0;
    end else begin
      regs_default_r <= (state_nxt == st_defaults) || (state_r == st_idle);
      otp_load_r <= (state_nxt == st_otp) && asg_r.programmed;
      otp_apply_r <= (state_r == st_otp) && otp_done && otp_crc_ok
                     && asg_r.programmed;
      eeprom_start_r <= (state_r == st_eeprom) && !result_r.eeprom_skip;
      pll_cal_r <= (state_nxt == st_pll);
      serial_ready_r <= (state_nxt == st_done);
    end
  end

  // register defaults: outputs off, pins inputs
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_en_r <= `RST_OUT_EN;
      gpio_dir_r <= `RST_GPIO_DIR;
    end else if (state_r == st_defaults) begin
      out_en_r <= `RST_OUT_EN;
      gpio_dir_r <= `RST_GPIO_DIR;
    end
  end

  cap_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    held_r && $past(held_r) |-> $stable(cap_r))
    else $error("captured straps changed after capture");
  port_sel_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_r == st_defaults |=> result_r.port_i2c == $past(cap_r[`PORT_SEL_PIN]))
    else $error("port select not from pin 9");
  addr_spi_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !result_r.port_i2c |-> !result_r.slave_address_bit_two)
    else $error("address bit set under spi");
  addr_none_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_r == st_defaults && asg_r.addr_mask == '0 |=> !result_r.slave_address_bit_two)
    else $error("address bit not zero without pin");
  ee_or_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_r == st_defaults |=> result_r.eeprom_skip == $past(|(asg_r.eedis_mask & cap_r)))
    else $error("eeprom disable not or of pins");
  ee_skip_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    result_r.eeprom_skip |-> !eeprom_start_r)
    else $error("eeprom started while disabled");
  def_sel_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_r == st_defaults && asg_r.sel_mask == '0
    |=> result_r.cfg_sel == {6'h00, $past(cap_r[3:0])})
    else $error("default select not pins 3 to 0");
  otp_blank_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !asg_r.programmed |-> !otp_load_r && !otp_apply_r)
    else $error("otp loaded on blank part");
  crc_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    otp_apply_r |-> $past(otp_crc_ok))
    else $error("bad configuration applied");
  order_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_r == st_otp |-> $past(state_r) inside {st_defaults, st_otp})
    else $error("otp before defaults");
  defaults_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !serial_ready_r |-> out_en_r == '0 && gpio_dir_r == '0)
    else $error("outputs enabled before loading");

  done_c: cover property (@(posedge core_clk) disable iff (!rst_b) serial_ready_r);
  skip_c: cover property (@(posedge core_clk) disable iff (!rst_b)
    state_r == st_eeprom && result_r.eeprom_skip);
  apply_c: cover property (@(posedge core_clk) disable iff (!rst_b) otp_apply_r);
  wr_c: cover property (@(posedge core_clk) disable iff (!rst_b) reg_wr && serial_ready_r);

endmodule // strap_cfg_loader

// ### src/strap_pack.sv
// packs selected strap bits in index order into a select word
// assumes inputs are stable captured values on the same clock
module strap_pack
  import strap_cfg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic load,
  input wire logic [`GPIO_COUNT-1:0] mask,
  input wire logic [`GPIO_COUNT-1:0] bits,
  output logic [`SEL_W-1:0] packed_r
);

  logic [`SEL_W-1:0] packed_nxt;

  always_comb begin
    int unsigned pos;
    pos = 0;
    packed_nxt = '0;
    for (int i = 0; i < `GPIO_COUNT; i++) begin
      if (mask[i]) begin
        packed_nxt[pos[`GPIO_IDX_W-1:0]] = bits[i];
        pos = pos + 1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      packed_r <= '0;
    end else if (load) begin
      packed_r <= packed_nxt;
    end
  end

endmodule // strap_pack

// ### tb/strap_board.sv
// board strap model: optional external drivers over the internal pull-ups
// assumes the bench changes drive_en and drive_val shortly after a clock edge
module strap_board (
  input wire logic [9:0] drive_en,
  input wire logic [9:0] drive_val,
  output logic [9:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // undriven pins read high through the pull-ups
  assign pins = (drive_en & drive_val) | ~drive_en;
endmodule // strap_board

// ### tb/tb_top.sv
// bench for the strap configuration loader: straps, sequence handshakes, serial writes
// assumes strap_cfg_pkg is compiled first and strap_board is in tb/
`include "strap_cfg_defines.svh"
module tb_top
  import strap_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0;
  logic rst_b = 0;
  logic [9:0] drive_en = 0;
  logic [9:0] drive_val = 0;
  logic [9:0] gpio_in;
  strap_assign_type assign_in = '0;
  logic otp_done = 0;
  logic otp_crc_ok = 0;
  logic eeprom_done = 0;
  logic pll_locked = 0;
  logic reg_wr = 0;
  logic reg_wr_i2c = 0;
  logic reg_wr_a2 = 1;
  strap_result_type result_r;
  strap_result_type prev_res;
  logic otp_load_r, otp_apply_r, eeprom_start_r, pll_cal_r, regs_default_r, serial_ready_r;
  logic [11:0] out_en_r;
  logic [9:0] gpio_dir_r;
  logic apply_seen, eeprom_seen, prev_ready;
  logic [36:0] exp_q[$];
  logic [31:0] lfsr_state = 32'h4545;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;

  always #4 core_clk = ~core_clk;

  strap_board u_strap_board (.drive_en(drive_en), .drive_val(drive_val), .pins(gpio_in));

  strap_cfg_loader u_strap_cfg_loader (.core_clk(core_clk), .rst_b(rst_b), .gpio_in(gpio_in),
    .assign_in(assign_in), .otp_done(otp_done), .otp_crc_ok(otp_crc_ok),
    .eeprom_done(eeprom_done), .pll_locked(pll_locked), .reg_wr(reg_wr),
    .reg_wr_i2c(reg_wr_i2c), .reg_wr_a2(reg_wr_a2), .result_r(result_r),
    .otp_load_r(otp_load_r), .otp_apply_r(otp_apply_r), .eeprom_start_r(eeprom_start_r),
    .pll_cal_r(pll_cal_r), .regs_default_r(regs_default_r), .out_en_r(out_en_r),
    .gpio_dir_r(gpio_dir_r), .serial_ready_r(serial_ready_r));

  task automatic rnd(output logic [31:0] v);
    lfsr_state = {lfsr_state[30:0], lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
    v = lfsr_state;
  endtask

  task automatic check(input logic [36:0] got, input logic [36:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    if (exp_q.size() != 0) miscompares++;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  function automatic strap_result_type expect_result(strap_assign_type a, logic [9:0] p);
    strap_result_type e;
    logic [9:0] m;
    int k;
    e = '0;
    k = 0;
    m = (a.programmed && a.sel_mask != 0) ? a.sel_mask : `DEF_SEL_MASK;
    e.port_i2c = p[`PORT_SEL_PIN];
    for (int i = 0; i < `GPIO_COUNT; i++) begin
      if (m[i]) begin
        e.cfg_sel[k] = p[i];
        k++;
      end
      if (a.programmed && a.addr_mask[i]) e.slave_address_bit_two = p[i] & p[`PORT_SEL_PIN];
    end
    e.eeprom_skip = a.programmed & (|(a.eedis_mask & p));
    return e;
  endfunction

  // sequence partner: answers each stage one cycle after it is requested
  always @(posedge core_clk) begin
    #1;
    otp_done = otp_load_r;
    eeprom_done = eeprom_start_r;
    pll_locked = pll_cal_r;
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      complete_run();
    end
  end

  always @(negedge core_clk) begin
    if (!rst_b) begin
      apply_seen = 0;
      eeprom_seen = 0;
      prev_ready = 0;
    end else begin
      apply_seen |= otp_apply_r;
      eeprom_seen |= eeprom_start_r;
      if (serial_ready_r && !prev_ready) begin
        check({34'h0, regs_default_r, otp_load_r, pll_cal_r}, 37'h0);
      end
      if (serial_ready_r && (!prev_ready || result_r !== prev_res)) begin
        if (exp_q.size() == 0) miscompares++;
        else check({result_r, out_en_r, gpio_dir_r, apply_seen, eeprom_seen},
                   exp_q.pop_front());
      end
      prev_ready = serial_ready_r;
      prev_res = result_r;
    end
  end

  task automatic run_case(input strap_assign_type a, input logic [9:0] en,
                          input logic [9:0] val, input logic crc);
    strap_result_type e;
    logic [31:0] r;
    int n;
    @(posedge core_clk);
    #1;
    rst_b = 0;
    assign_in = a;
    drive_en = en;
    drive_val = val;
    otp_crc_ok = crc;
    e = expect_result(a, (en & val) | ~en);
    exp_q.push_back({e, 12'h000, 10'h000, a.programmed & crc, ~e.eeprom_skip});
    repeat (5) @(posedge core_clk);
    #1;
    rst_b = 1;
    repeat (6) @(posedge core_clk);
    #1;
    rnd(r);
    drive_en = r[9:0];
    drive_val = r[19:10];
    reg_wr_i2c = ~e.port_i2c;
    reg_wr = 1;
    @(posedge core_clk);
    #1;
    reg_wr = 0;
    n = 0;
    while (!serial_ready_r && n < 1000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    e.port_i2c = ~e.port_i2c;
    e.slave_address_bit_two = e.port_i2c;
    exp_q.push_back({e, 12'h000, 10'h000, a.programmed & crc, ~e.eeprom_skip});
    reg_wr_i2c = e.port_i2c;
    reg_wr = 1;
    @(posedge core_clk);
    #1;
    reg_wr = 0;
    repeat (3) @(posedge core_clk);
    $display("case done at %0t", $time);
  endtask

  initial begin
    strap_assign_type a;
    logic [31:0] r;
    logic [31:0] p;
    run_case('0, 10'h000, 10'h000, 1'b1);
    a = '{sel_mask: 10'h0A4, addr_mask: 10'h042, eedis_mask: 10'h011, programmed: 1'b1};
    run_case(a, 10'h3FF, 10'h2C1, 1'b1);
    a = '{sel_mask: 10'h1F8, addr_mask: 10'h004, eedis_mask: 10'h000, programmed: 1'b1};
    run_case(a, 10'h3FF, 10'h0AC, 1'b0);
    for (int t = 0; t < 5; t++) begin
      rnd(r);
      rnd(p);
      a.sel_mask = {2'b00, r[7:0]};
      a.addr_mask = (10'h001 << (r[11:8] % 9)) & ~a.sel_mask;
      a.eedis_mask = (10'h001 << (r[15:12] % 9)) & ~a.sel_mask & ~a.addr_mask;
      a.programmed = r[16];
      run_case(a, p[9:0], p[19:10], r[17]);
    end
    complete_run();
  end
endmodule // tb_top
